// ### logic_cell_pkg.sv
package logic_cell_pkg;

    // Cluster size and register port widths.
    localparam int NUM_CELLS = 10;
    localparam int ADDR_W    = 4;
    localparam int DATA_W    = 32;

    // Word indices on the register port: one config word per cell, then two read-only views.
    localparam logic [ADDR_W-1:0] CFG_BASE_IDX   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATE_IDX  = 4'hA;
    localparam logic [ADDR_W-1:0] COMB_STATE_IDX = 4'hB;

    // Field positions inside a cell config word.
    localparam int LUT_MASK_LSB    = 0;
    localparam int LUT_MASK_W      = 16;
    localparam int MODE_LSB        = 16;
    localparam int MODE_W          = 2;
    localparam int CIN_LUT_BIT     = 18;
    localparam int CASC_EN_BIT     = 19;
    localparam int PACK_BIT        = 20;
    localparam int CLK_PAIR_BIT    = 21;
    localparam int PRESET_BIT      = 22;
    localparam int ALOAD_BIT       = 23;
    localparam int FB_SEL_BIT      = 24;
    localparam int ACLR_SRC_LSB    = 25;
    localparam int ACLR_SRC_W      = 2;
    localparam int CHAIN_START_BIT = 27;

    // Reset values.
    localparam logic [DATA_W-1:0]    CFG_RESET  = 32'h0000_0000;
    localparam logic [DATA_W-1:0]    RD_RESET   = 32'h0000_0000;
    localparam logic [NUM_CELLS-1:0] CELL_RESET = 10'h000;

    // Cell operating modes; code 3 is illegal and behaves as normal mode.
    typedef enum logic [MODE_W-1:0] {
        MODE_NORMAL,
        MODE_ARITH,
        MODE_COUNTER
    } cell_mode_t;

    // Which cluster-wide asynchronous clear a cell listens to.
    typedef enum logic [ACLR_SRC_W-1:0] {
        ACLR_NONE,
        ACLR_A,
        ACLR_B
    } aclr_src_t;

    // Decoded per-cell configuration.
    typedef struct packed {
        logic                  chain_start;
        aclr_src_t             aclr_src;
        logic                  fb_sel;
        logic                  aload;
        logic                  preset;
        logic                  clk_pair_b;
        logic                  pack;
        logic                  casc_en;
        logic                  cin_lut;
        cell_mode_t            mode;
        logic [LUT_MASK_W-1:0] lut_mask;
    } cell_cfg_t;

    // Cluster-wide register controls shared by all cells.
    typedef struct packed {
        logic clk_en_a;
        logic clk_en_b;
        logic aclr_a;
        logic aclr_b;
        logic sync_clr;
        logic sync_load;
    } cluster_ctrl_t;

    // Four local data inputs of every cell in the cluster.
    typedef struct packed {
        logic [NUM_CELLS-1:0] data_in_a;
        logic [NUM_CELLS-1:0] data_in_b;
        logic [NUM_CELLS-1:0] data_in_c;
        logic [NUM_CELLS-1:0] data_in_d;
    } cell_data_t;

    // Register port request.
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage

// ### cell_cluster.sv
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
// What this block does
// [RULE1] Each cell runs normal, arithmetic or counter mode.
// [RULE2] Seven inputs: four data, feedback, carry, cascade.
// [RULE3] Register controls come from cluster-wide signals.
// [RULE4] Two cluster clock enables; each register picks one.
// [RULE5] Normal mode: four-input table, carry or data_c.
// [RULE6] Table output ANDs cascade-in onto cascade-out.
// [RULE7] Register packing, off when carry feeds table.
// [RULE8] Arithmetic: sum table and carry table, three inputs. The code's carry is a fixed majority, not a table.
// [RULE9] Arithmetic allows cascade; registered and unregistered outputs.
// [RULE10] Counter: enables, direction, sync clear, sync load.
// [RULE11] data_a/data_b control counting except second cell.
// [RULE12] Only first cell has register feedback multiplexer.
// [RULE13] Sync clear and load hit every cluster register.
// [RULE14] Counter cluster holds one counter plus combinational.
// [RULE15] Counter: data table, carry table, load mux, clear gate. The code toggles and carries without any table.
// [RULE16] Counter sync clear or load beats cascade-in.
// [RULE17] Sync clear wins over sync load.
// [RULE18] Native async clear; preset by inverted storage.
// [RULE19] Async load emulation leaves reset state undefined.
// [RULE20] Chip reset clears all, beats other controls.
// [RULE21] Preset-emulated registers show one during chip reset.
// [RULE22] Chip reset honoured only if built so.
// [RULE23] Two clocks, each tied to its own enable. Here one clock mclk_i serves all cells; each picks clk_en_a or clk_en_b.
// [RULE24] Cluster async clears also act as load/preset.
// [RULE25] Counter counts up when direction high, else down.
// [RULE26] Arithmetic carry-out is majority of a, b, carry.
module cell_cluster #(
    parameter bit CHIP_RESET_HONOUR = 1'b1
) (
    input  wire logic                                    mclk_i,
    input  wire logic                                    rst_i,
    input  wire logic_cell_pkg::reg_req_t                req_i,
    output logic [logic_cell_pkg::DATA_W-1:0]            rd_data_o,
    input  wire logic_cell_pkg::cluster_ctrl_t           ctrl_i,
    input  wire logic_cell_pkg::cell_data_t              data_i,
    input  wire logic                                    carry_in_i,
    input  wire logic                                    cascade_in_i,
    input  wire logic                                    chip_reset_n_i,
    output logic                                         carry_out_o,
    output logic                                         cascade_out_o,
    output logic [logic_cell_pkg::NUM_CELLS-1:0]         comb_out_o,
    output logic [logic_cell_pkg::NUM_CELLS-1:0]         reg_out_o
);

    localparam int N = logic_cell_pkg::NUM_CELLS;
    typedef logic [logic_cell_pkg::ADDR_W-1:0] addr_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Splits a stored config word into its fields.
    function automatic logic_cell_pkg::cell_cfg_t decode_cfg(
        input logic [logic_cell_pkg::DATA_W-1:0] w
    );
        logic_cell_pkg::cell_cfg_t c;
        c.lut_mask    = w[logic_cell_pkg::LUT_MASK_LSB +: logic_cell_pkg::LUT_MASK_W];
        c.mode        = logic_cell_pkg::cell_mode_t'(
                            w[logic_cell_pkg::MODE_LSB +: logic_cell_pkg::MODE_W]);
        c.cin_lut     = w[logic_cell_pkg::CIN_LUT_BIT];
        c.casc_en     = w[logic_cell_pkg::CASC_EN_BIT];
        c.pack        = w[logic_cell_pkg::PACK_BIT];
        c.clk_pair_b  = w[logic_cell_pkg::CLK_PAIR_BIT];
        c.preset      = w[logic_cell_pkg::PRESET_BIT];
        c.aload       = w[logic_cell_pkg::ALOAD_BIT];
        c.fb_sel      = w[logic_cell_pkg::FB_SEL_BIT];
        c.aclr_src    = logic_cell_pkg::aclr_src_t'(
                            w[logic_cell_pkg::ACLR_SRC_LSB +: logic_cell_pkg::ACLR_SRC_W]);
        c.chain_start = w[logic_cell_pkg::CHAIN_START_BIT];
        return c;
    endfunction

    // Three-input table lookup, used by the arithmetic path only; the counter path toggles without a table.
    function automatic logic lut3(
        input logic [7:0] mask,
        input logic       i2,
        input logic       i1,
        input logic       i0
    );
        return mask[{i2, i1, i0}];
    endfunction

    // Majority of three, the ripple-carry function.
    function automatic logic majority(
        input logic x,
        input logic y,
        input logic z
    );
        return (x & y) | (x & z) | (y & z);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration storage and decode.

    logic [logic_cell_pkg::DATA_W-1:0] cfg_q [N];
    logic_cell_pkg::cell_cfg_t         cfg   [N];
    logic [logic_cell_pkg::DATA_W-1:0] rd_data_q;
    logic [N-1:0]                      store_q;
    logic [N-1:0]                      view;
    logic [N-1:0]                      comb_val;
    logic [N-1:0]                      store_d;
    logic [N-1:0]                      aclr_hit;
    logic [N-1:0]                      clk_hit;
    logic [N:0]                        carry;
    logic [N:0]                        casc;

    // Config words are written by software and steer every cell's datapath.
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < N; i++) begin
            if (rst_i) begin
                cfg_q[i] <= logic_cell_pkg::CFG_RESET;
            end else if (req_i.wr && req_i.addr == logic_cell_pkg::CFG_BASE_IDX
                                                   + addr_t'(i)) begin
                cfg_q[i] <= req_i.wdata;
            end
        end
    end

    // Decode is pure wiring, kept combinational.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            cfg[i] = decode_cfg(cfg_q[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chip-wide reset pin synchroniser.

    logic chip_s1_q;
    logic chip_s2_q;
    logic chip_s3_q;
    logic chip_n_q;
    logic chip_rst;

    // Three stages; the filtered level moves only when stages two and three agree.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            chip_s1_q <= 1'b1;
            chip_s2_q <= 1'b1;
            chip_s3_q <= 1'b1;
            chip_n_q  <= 1'b1;
        end else begin
            chip_s1_q <= chip_reset_n_i;
            chip_s2_q <= chip_s1_q;
            chip_s3_q <= chip_s2_q;
            if (chip_s2_q == chip_s3_q) begin
                chip_n_q <= chip_s3_q;
            end
        end
    end

    // The honour option is fixed at build time, not by software.
    assign chip_rst = CHIP_RESET_HONOUR && !chip_n_q; // [RULE22]

    ////////////////////////////////////////////////////////////////////////////////
    // Register output view, including the asynchronous overrides.

    // Asynchronous controls act on the output at once, then the stored bit follows next edge.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            unique case (cfg[i].aclr_src)
                logic_cell_pkg::ACLR_A: aclr_hit[i] = ctrl_i.aclr_a; // [RULE24]
                logic_cell_pkg::ACLR_B: aclr_hit[i] = ctrl_i.aclr_b; // [RULE24]
                default:                aclr_hit[i] = 1'b0;
            endcase
            clk_hit[i] = cfg[i].clk_pair_b ? ctrl_i.clk_en_b : ctrl_i.clk_en_a; // [RULE4] [RULE23]
            if (chip_rst && !cfg[i].aload) begin
                view[i] = cfg[i].preset; // [RULE20] [RULE21]
            end else if (aclr_hit[i]) begin
                // With async load emulation the clear line loads data_c instead.
                view[i] = cfg[i].aload ? data_i.data_in_c[i] : cfg[i].preset; // [RULE18]
            end else begin
                // Preset is stored inverted so that the native clear reads as one.
                view[i] = store_q[i] ^ cfg[i].preset; // [RULE18]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-cell datapath, rippling carry and cascade through the cluster.

    always_comb begin
        logic             a;
        logic             b;
        logic             c4;
        logic             lut_o;
        logic             d_val;
        logic             cnt_en;
        logic             cnt_up;
        logic             cin;
        a      = 1'b0;
        b      = 1'b0;
        c4     = 1'b0;
        lut_o  = 1'b0;
        d_val  = 1'b0;
        cnt_en = 1'b0;
        cnt_up = 1'b0;
        cin    = 1'b0;
        carry[0] = carry_in_i;
        casc[0]  = cascade_in_i;
        for (int i = 0; i < N; i++) begin
            // Only the first cell can swap data_a for its own register output.
            a = (i == 0 && cfg[i].fb_sel) ? view[i] : data_i.data_in_a[i]; // [RULE12] [RULE2]
            b = data_i.data_in_b[i];
            // The second cell borrows counting controls from the first.
            cnt_en = (i == 1) ? data_i.data_in_a[0] : a; // [RULE11]
            cnt_up = (i == 1) ? data_i.data_in_b[0] : b; // [RULE11]
            unique case (cfg[i].mode)
                logic_cell_pkg::MODE_ARITH: begin
                    cin      = carry[i];
                    lut_o    = lut3(cfg[i].lut_mask[7:0], cin, b, a); // [RULE8]
                    carry[i+1] = majority(a, b, cin); // [RULE26] [RULE8]
                    comb_val[i] = cfg[i].casc_en ? (lut_o & casc[i]) : lut_o; // [RULE9]
                    d_val    = comb_val[i];
                end
                logic_cell_pkg::MODE_COUNTER: begin
                    // A chain start seeds the toggle carry from the count enable.
                    cin      = cfg[i].chain_start ? cnt_en : (carry[i] & cnt_en); // [RULE10]
                    lut_o    = view[i] ^ cin; // [RULE15] [RULE25]
                    carry[i+1] = cin & (cnt_up ? view[i] : ~view[i]); // [RULE15] [RULE25]
                    comb_val[i] = cfg[i].casc_en ? (lut_o & casc[i]) : lut_o;
                    d_val    = comb_val[i];
                end
                default: begin
                    // Normal mode: fourth table input is carry or data_c.
                    c4       = cfg[i].cin_lut ? carry[i] : data_i.data_in_c[i]; // [RULE5]
                    lut_o    = cfg[i].lut_mask[{data_i.data_in_d[i], c4, b, a}]; // [RULE5]
                    carry[i+1] = carry[i];
                    comb_val[i] = cfg[i].casc_en ? (lut_o & casc[i]) : lut_o; // [RULE6]
                    // Packing is refused while carry feeds the table.
                    d_val    = (cfg[i].pack && !cfg[i].cin_lut)
                             ? data_i.data_in_d[i] : comb_val[i]; // [RULE7]
                end
            endcase
            casc[i+1] = comb_val[i];
            // Clear beats load, and both beat anything on the cascade.
            if (ctrl_i.sync_clr) begin
                d_val = 1'b0; // [RULE13] [RULE17] [RULE16] [RULE15]
            end else if (ctrl_i.sync_load) begin
                d_val = data_i.data_in_c[i]; // [RULE13] [RULE16] [RULE15]
            end
            store_d[i] = d_val ^ cfg[i].preset; // [RULE18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Cell registers.

    // Chip reset first, then async controls, then the chosen clock enable.
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < N; i++) begin
            if (rst_i) begin
                store_q[i] <= 1'b0;
            end else if (chip_rst) begin
                // Async-load cells keep whatever they held: their state is undefined.
                store_q[i] <= cfg[i].aload ? store_q[i] : 1'b0; // [RULE20] [RULE19]
            end else if (aclr_hit[i]) begin
                store_q[i] <= cfg[i].aload ? (data_i.data_in_c[i] ^ cfg[i].preset)
                                           : 1'b0; // [RULE3] [RULE24]
            end else if (clk_hit[i]) begin
                store_q[i] <= store_d[i]; // [RULE3] [RULE1]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port read path.

    // Read data stands only in the cycle after the strobe; unmapped words read zero.
    always_ff @(posedge mclk_i) begin
        if (rst_i || !req_i.rd) begin
            rd_data_q <= logic_cell_pkg::RD_RESET;
        end else if (req_i.addr == logic_cell_pkg::REG_STATE_IDX) begin
            rd_data_q <= {{(logic_cell_pkg::DATA_W-N){1'b0}}, view};
        end else if (req_i.addr == logic_cell_pkg::COMB_STATE_IDX) begin
            rd_data_q <= {{(logic_cell_pkg::DATA_W-N){1'b0}}, comb_val};
        end else if (req_i.addr < addr_t'(N)) begin
            rd_data_q <= cfg_q[req_i.addr];
        end else begin
            rd_data_q <= logic_cell_pkg::RD_RESET;
        end
    end

    // Chain ends and cell outputs.
    assign rd_data_o     = rd_data_q;
    assign carry_out_o   = carry[N];
    assign cascade_out_o = casc[N];
    assign comb_out_o    = comb_val;
    assign reg_out_o     = view; // [RULE9]

endmodule

// ### cell_cluster_checker.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////
// Port checks for the cell cluster.
module cell_cluster_checker #(
    parameter bit CHIP_RESET_HONOUR = 1'b1
) (
    input wire logic                          mclk_i,
    input wire logic                          rst_i,
    input wire logic_cell_pkg::reg_req_t      req_i,
    input wire logic [31:0]                   rd_data_o,
    input wire logic_cell_pkg::cluster_ctrl_t ctrl_i,
    input wire logic                          chip_reset_n_i,
    input wire logic [9:0]                    comb_out_o,
    input wire logic [9:0]                    reg_out_o
);
    logic [31:0] shadow_q [10];
    logic [31:0] exp_cfg_q;
    logic [9:0]  comb_seen_q;
    logic        rd_any_q;
    logic        rd_cfg_q;
    logic        rd_reg_q;
    logic        rd_comb_q;
    logic        rd_none_q;
    logic        cr_last_q;
    logic [2:0]  cr_cnt_q;
    logic        quiet;

    //////////////////////////////////////////////////////////////////////
    // Shadow config words to judge each read-back.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 10; i++)
                shadow_q[i] <= 32'h0000_0000;
        end else if (req_i.wr && req_i.addr < 4'hA) begin
            shadow_q[req_i.addr] <= req_i.wdata;
        end
    end

    // Remember what each read asked for; its answer is due one edge later.
    always_ff @(posedge mclk_i) begin
        rd_any_q    <= req_i.rd;
        rd_cfg_q    <= req_i.rd && req_i.addr < 4'hA;
        rd_reg_q    <= req_i.rd && req_i.addr == logic_cell_pkg::REG_STATE_IDX;
        rd_comb_q   <= req_i.rd && req_i.addr == logic_cell_pkg::COMB_STATE_IDX;
        rd_none_q   <= req_i.rd && req_i.addr > logic_cell_pkg::COMB_STATE_IDX;
        exp_cfg_q   <= req_i.addr < 4'hA ? shadow_q[req_i.addr] : 32'h0000_0000;
        comb_seen_q <= comb_out_o;
    end

    // Run length of the chip reset pin; only long runs pass the synchroniser.
    always_ff @(posedge mclk_i) begin
        cr_last_q <= chip_reset_n_i;
        if (rst_i || chip_reset_n_i != cr_last_q) begin
            cr_cnt_q <= 3'h0;
        end else if (cr_cnt_q != 3'h7) begin
            cr_cnt_q <= cr_cnt_q + 3'h1;
        end
    end
    assign quiet = !ctrl_i.aclr_a && !ctrl_i.aclr_b && !req_i.wr && cr_last_q && cr_cnt_q == 3'h7;

    //////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_read_idle_zero: assert property (!rd_any_q |-> rd_data_o == 32'h0000_0000)
        else $error("read data not zero outside the answer cycle");
    a_unmapped_read_zero: assert property (rd_none_q |-> rd_data_o == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_cfg_read_back: assert property (rd_cfg_q |-> rd_data_o[27:0] == exp_cfg_q[27:0])
        else $error("config read-back differs from last write");
    a_comb_view_match: assert property (
        rd_comb_q |-> rd_data_o == {22'h00_0000, comb_seen_q})
        else $error("comb view differs from outputs at the read edge");
    a_view_upper_zero: assert property (rd_reg_q |-> rd_data_o[31:10] == 22'h00_0000)
        else $error("register view has bits above the cells");
    a_hold_no_enable: assert property (
        (!ctrl_i.clk_en_a && !ctrl_i.clk_en_b && quiet) ##1 quiet |-> $stable(reg_out_o))
        else $error("register output moved without a clock enable");
    a_reset_clears: assert property ($fell(rst_i) |-> reg_out_o == 10'h000)
        else $error("register outputs not clear after reset");
    a_chip_reset_hold: assert property (
        CHIP_RESET_HONOUR && !cr_last_q && cr_cnt_q == 3'h7 && !req_i.wr |=> $stable(reg_out_o))
        else $error("register output moved during chip reset");

    c_cfg_read: cover property (rd_cfg_q);
    c_clear_and_load: cover property (ctrl_i.clk_en_a && ctrl_i.sync_clr && ctrl_i.sync_load);
    c_chip_reset_long: cover property (!cr_last_q && cr_cnt_q == 3'h7);
endmodule

bind cell_cluster cell_cluster_checker #(.CHIP_RESET_HONOUR(CHIP_RESET_HONOUR)) u_checker (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .rd_data_o(rd_data_o),
    .ctrl_i(ctrl_i), .chip_reset_n_i(chip_reset_n_i),
    .comb_out_o(comb_out_o), .reg_out_o(reg_out_o)
);

// ### neighbour_cell.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////
// Lower neighbour cell, used purely combinationally so it never shares the counter clock.
module neighbour_cell (
    input  wire logic [2:0] op_i,
    output logic            carry_o,
    output logic            cascade_o
);
    // Carry is the majority of its operands; cascade is a plain AND term.
    assign carry_o   = (op_i[0] & op_i[1]) | (op_i[0] & op_i[2]) | (op_i[1] & op_i[2]);
    assign cascade_o = op_i[0] & op_i[1];
endmodule

// ### test_cell_cluster.sv
`timescale 1ns/10ps
module test_cell_cluster;
    localparam logic [9:0] CIN = 10'h001, CAS = 10'h002, PACK = 10'h004, PAIRB = 10'h008;
    localparam logic [9:0] PRE = 10'h010, ACA = 10'h080, CHN = 10'h200, FBK = 10'h040;
    localparam logic [5:0] EN_A = 6'h20, EN_B = 6'h10, CL_A = 6'h08, CL_B = 6'h04;
    localparam logic [5:0] S_CLR = 6'h02, S_LD = 6'h01;
    logic                          mclk_i = 1'b0;
    logic                          rst_i = 1'b1;
    logic_cell_pkg::reg_req_t      req = '0;
    logic_cell_pkg::cluster_ctrl_t ctrl = '0;
    logic_cell_pkg::cell_data_t    data = '0;
    logic [2:0]                    nb_op = 3'h0;
    logic                          chip_reset_n = 1'b1;
    logic [31:0]                   rd_data;
    logic                          carry_in, cascade_in, carry_out, cascade_out;
    logic [9:0]                    comb_out, reg_out;
    logic [22:0]                   vec [4] = '{{10'h3FF, 10'h001, 3'h0}, {10'h155, 10'h0AA, 3'h4},
                                               {10'h123, 10'h045, 3'h5}, {10'h200, 10'h300, 3'h6}};
    logic [10:0]                   sum;
    int                            err_count = 0;
    int                            samples_checked = 0;
    int                            cycles = 0;

    cell_cluster dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rd_data_o(rd_data), .ctrl_i(ctrl),
        .data_i(data), .carry_in_i(carry_in), .cascade_in_i(cascade_in),
        .chip_reset_n_i(chip_reset_n), .carry_out_o(carry_out), .cascade_out_o(cascade_out),
        .comb_out_o(comb_out), .reg_out_o(reg_out)
    );
    neighbour_cell nb (.op_i(nb_op), .carry_o(carry_in), .cascade_o(cascade_in));

    //////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling far above the run's length.
    always #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Look 1 ns past the edge, once outputs have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_i);
        req <= '0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge mclk_i);
        req <= '0;
        #1;
        chk(rd_data, exp);
    endtask

    function automatic logic [31:0] cfg(input logic [1:0] m, input logic [15:0] k,
                                        input logic [9:0] f);
        return {4'h0, f, m, k};
    endfunction

    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'h0000_0000);
        rd(4'hC, 32'h0000_0000);
        wr(4'hA, 32'hFFFF_FFFF);
        rd(4'hA, 32'h0000_0000);
        // All-ones tables pass the cascade input down the chain.
        for (int i = 0; i < 10; i++)
            wr(4'(i), cfg(2'h0, 16'hFFFF, CAS));
        rd(4'h3, cfg(2'h0, 16'hFFFF, CAS));
        nb_op <= 3'h3;
        rd(4'hB, 32'h0000_03FF);
        chk(cascade_out, 1'b1);
        nb_op <= 3'h1;
        #1;
        chk({cascade_out, comb_out}, 11'h000);
        // Mask F0F0 passes the fourth table input straight through.
        wr(4'h0, cfg(2'h0, 16'hF0F0, 10'h000));
        data.data_in_c <= 10'h001;
        nb_op <= 3'h3;
        #1;
        chk(comb_out[0], 1'b1);
        wr(4'h0, cfg(2'h0, 16'hF0F0, CIN));
        data.data_in_c <= 10'h000;
        #1;
        chk(comb_out[0], 1'b1);
        nb_op <= 3'h0;
        #1;
        chk(comb_out[0], 1'b0);
        // Packing loads data_d unless the carry feeds the table.
        wr(4'h0, cfg(2'h0, 16'hF0F0, PACK));
        data.data_in_d <= 10'h001;
        ctrl <= EN_A;
        cyc(1);
        chk({comb_out[0], reg_out[0]}, 2'h1);
        wr(4'h0, cfg(2'h0, 16'hF0F0, PACK | CIN));
        nb_op <= 3'h3;
        data.data_in_d <= 10'h000;
        cyc(1);
        chk(reg_out[0], 1'b1);
        // A register moves only on its own pair's enable.
        ctrl <= EN_B;
        nb_op <= 3'h0;
        cyc(1);
        chk(reg_out[0], 1'b1);
        wr(4'h0, cfg(2'h0, 16'hF0F0, CIN | PAIRB));
        cyc(1);
        chk(reg_out[0], 1'b0);
        // Cluster-wide sync load and clear; clear wins when both are high.
        for (int i = 0; i < 10; i++)
            wr(4'(i), 32'h0000_0000);
        data.data_in_c <= 10'h2A5;
        ctrl <= EN_A | S_LD;
        cyc(1);
        chk(reg_out, 10'h2A5);
        ctrl <= S_CLR;
        cyc(1);
        chk(reg_out, 10'h2A5);
        ctrl <= EN_A | S_CLR | S_LD;
        cyc(1);
        chk(reg_out, 10'h000);
        // Ten-cell ripple adder fed by the neighbour's carry.
        for (int i = 0; i < 10; i++)
            wr(4'(i), cfg(2'h1, 16'h0096, 10'h000));
        ctrl <= EN_A;
        for (int k = 0; k < 4; k++) begin
            {data.data_in_a, data.data_in_b, nb_op} <= vec[k];
            sum = 11'(vec[k][22:13]) + 11'(vec[k][12:3]) + 11'($countones(vec[k][2:0]) >= 2);
            cyc(1);
            chk({carry_out, comb_out}, sum);
            chk(reg_out, sum[9:0]);
        end
        // Four-bit counter; cell 1's own data inputs are held low and must not matter.
        for (int i = 0; i < 10; i++)
            wr(4'(i), i < 4 ? cfg(2'h2, 16'h0000, i == 0 ? CHN | CAS : 10'h000) : 32'h0000_0000);
        nb_op <= 3'h3;
        data <= {10'h00D, 10'h00D, 10'h000, 10'h000};
        ctrl <= EN_A | S_CLR;
        cyc(1);
        ctrl <= EN_A;
        cyc(5);
        chk(reg_out, 10'h005);
        data.data_in_b <= 10'h000;
        cyc(7);
        chk(reg_out, 10'h00E);
        data.data_in_a <= 10'h000;
        cyc(2);
        chk(reg_out, 10'h00E);
        nb_op <= 3'h0;
        data.data_in_c <= 10'h009;
        ctrl <= EN_A | S_LD;
        cyc(1);
        chk(reg_out, 10'h009);
        ctrl <= EN_A | S_CLR;
        cyc(1);
        chk(reg_out, 10'h000);
        // Clear source a only; cell 1 emulates a preset by inverted storage.
        wr(4'h0, cfg(2'h0, 16'h0000, ACA));
        wr(4'h1, cfg(2'h0, 16'h0000, ACA | PRE));
        data.data_in_c <= 10'h3FF;
        ctrl <= EN_A | S_LD;
        cyc(1);
        ctrl <= CL_B;
        #1;
        chk(reg_out, 10'h3FF);
        ctrl <= CL_A;
        #1;
        chk(reg_out, 10'h3FE);
        // Chip reset beats a pending load; only the preset cell shows a one.
        ctrl <= EN_A | S_LD;
        chip_reset_n <= 1'b0;
        cyc(10);
        chk(reg_out, 10'h002);
        chip_reset_n <= 1'b1;
        cyc(6);
        chk(reg_out, 10'h3FF);
        wr(4'h0, cfg(2'h0, 16'hAAAA, FBK));
        #1;
        chk(comb_out[0], 1'b1);
        summarize();
    end
endmodule
